//--- sr_map.svh
`ifndef SR_MAP_SVH
`define SR_MAP_SVH
// ==========================================================
// mode register addresses
`define SR_MA_BANK_MASK 8'h10
`define SR_MA_SEG_MASK 8'h11
// reset values of the mask registers (all refreshed)
`define SR_BANK_MASK_RST 8'h00
`define SR_SEG_MASK_RST 8'h00
// ==========================================================
// timing, in ns at the system clock
`define SR_CLK_NS 40
`define SR_TCKESR_NS 15
`define SR_TXSR_NS 140
`define SR_TREFI_NS 3900
// least times round up, at least one cycle
`define SR_CKESR_CYC ((`SR_TCKESR_NS + `SR_CLK_NS - 1) / `SR_CLK_NS)
`define SR_XSR_CYC ((`SR_TXSR_NS + `SR_CLK_NS - 1) / `SR_CLK_NS)
// longest interval rounds down
`define SR_REFI_CYC (`SR_TREFI_NS / `SR_CLK_NS)
// ==========================================================
// command bus field positions
`define SR_CA_W 10
`define SR_MA_LO_POS 4
`define SR_OP_POS 2
`endif

//--- sr_pkg.sv
// ==========================================================
// types shared by the self refresh block
package sr_pkg;
   // command/address pins sampled at one clock edge
   typedef struct packed {
      logic cke; // clock enable
      logic cs_b; // chip select, active low
      logic [9:0] ca_r; // rising edge half
      logic [9:0] ca_f; // falling edge half
   } sr_cmd_t;
   // operating state of the device
   typedef enum logic [1:0] {
      SR_ST_IDLE,
      SR_ST_PD,
      SR_ST_SREF,
      SR_ST_XSR
   } sr_state_t;
   // device status
   typedef struct packed {
      logic in_sref; // self refresh resident
      logic in_pd; // power-down resident
      logic exiting; // inside exit interval
      logic cmd_ready; // normal decoding active
      logic int_clk_en; // internal clock running
   } sr_status_t;
   // one internal refresh step
   typedef struct packed {
      logic fire; // refresh issued this cycle
      logic [7:0] banks; // banks refreshed
      logic [2:0] seg; // segment of the row
      logic [5:0] row; // row counter
   } sr_ref_t;
endpackage : sr_pkg

//--- sr_self_refresh.sv
`timescale 1ns/100ps
`include "sr_map.svh"
// How it works
// - entry is cke low, cs low, ca 001
// - stay in self refresh while cke low
// - ignore all inputs but cke in self refresh
// - refresh at once, stop internal clock
// - tXSR timing starts at first cke-high edge
// - no refresh at all in power-down
// - bank mask written at mode address 10h
// - masked bank never refreshed in self refresh; all-bank refresh ignores the mask
// - unmasked bank follows the segment mask
// - segment mask at 11h covers all banks
// - masked segment rows are skipped
// - all-bank refresh only when all idle
module sr_self_refresh #(
   parameter int NBANK = 8, // banks, up to 8
   parameter int SEG_W = 3, // segment index width
   parameter int ROW_W = 6 // internal row counter width
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // command bus
   input wire sr_pkg::sr_cmd_t i_cmd,
   // status and refresh activity
   output sr_pkg::sr_status_t o_status,
   output sr_pkg::sr_ref_t o_ref,
   output logic o_refab,
   output logic [7:0] o_banks_open,
   // mask register contents
   output logic [7:0] o_bank_mask,
   output logic [7:0] o_seg_mask
);
   // ==========================================================
   // elaboration checks
   if (NBANK < 1 || NBANK > 8) begin : g_bad_nbank
      $error("NBANK must be 1 to 8");
   end
   if (SEG_W != 3 || ROW_W < SEG_W || ROW_W > 6) begin : g_bad_row
      $error("SEG_W must be 3, ROW_W 3 to 6");
   end

   localparam logic [7:0] XSR_LAST = 8'(`SR_XSR_CYC - 1);
   localparam logic [7:0] REFI_LAST = 8'(`SR_REFI_CYC - 1);

   // ==========================================================
   // registers
   sr_pkg::sr_state_t state_r, state_nxt; // device state
   logic cke_prev_r; // cke at previous edge
   logic [7:0] bank_mask_r; // per-bank refresh block
   logic [7:0] seg_mask_r; // per-segment refresh block
   logic [7:0] open_r, open_nxt; // banks with an open row
   logic [7:0] xsr_cnt_r; // exit interval counter
   logic [7:0] refi_cnt_r; // internal refresh timer
   logic [ROW_W-1:0] row_r; // internal row counter
   sr_pkg::sr_ref_t ref_r; // registered refresh step
   logic refab_r; // registered refresh accept

   // ==========================================================
   // command decode
   wire cmd_sel = !i_cmd.cs_b;
   wire ca_ref = !i_cmd.ca_r[0] && !i_cmd.ca_r[1] && i_cmd.ca_r[2];
   wire in_idle = (state_r == sr_pkg::SR_ST_IDLE);
   // cke falls this edge with entry pattern
   wire sre_hit = in_idle && cke_prev_r && !i_cmd.cke && cmd_sel &&
                  ca_ref;
   // cke falls with any other command: power-down
   wire pd_hit = in_idle && cke_prev_r && !i_cmd.cke && !sre_hit;
   // normal commands need cke high now and before
   wire live = in_idle && cke_prev_r && i_cmd.cke && cmd_sel;
   wire ref_hit = live && ca_ref;
   wire mrw_hit = live && (i_cmd.ca_r[3:0] == 4'h0);
   wire act_hit = live && !i_cmd.ca_r[0] && i_cmd.ca_r[1];
   wire pre_hit = live && (i_cmd.ca_r[3:0] == 4'hb);
   wire pre_all = i_cmd.ca_r[4];
   wire [2:0] bank_sel = i_cmd.ca_r[9:7];
   // mode address and operand
   wire [7:0] mr_addr = {i_cmd.ca_f[1:0],
                         i_cmd.ca_r[`SR_CA_W-1:`SR_MA_LO_POS]};
   wire [7:0] mr_op = i_cmd.ca_f[`SR_CA_W-1:`SR_OP_POS];
   wire wr_bank = mrw_hit && (mr_addr == `SR_MA_BANK_MASK);
   wire wr_seg = mrw_hit && (mr_addr == `SR_MA_SEG_MASK);
   // refresh accepted only with every bank idle
   wire refab_ok = ref_hit && (open_r == 8'h00);

   // ==========================================================
   // internal refresh selection
   wire in_sref = (state_r == sr_pkg::SR_ST_SREF);
   wire tick = in_sref && (refi_cnt_r == 8'h00);
   wire [SEG_W-1:0] seg_now = row_r[ROW_W-1 -: SEG_W];
   wire [7:0] bank_en = ~bank_mask_r;
   wire seg_ok = !seg_mask_r[seg_now];
   wire [7:0] ref_banks = seg_ok ? bank_en : 8'h00;

   // ==========================================================
   // next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         sr_pkg::SR_ST_IDLE: begin
            if (sre_hit) begin
               state_nxt = sr_pkg::SR_ST_SREF;
            end else if (pd_hit) begin
               state_nxt = sr_pkg::SR_ST_PD;
            end
         end
         sr_pkg::SR_ST_PD: begin
            // no refresh here; leave on cke high
            if (i_cmd.cke) begin
               state_nxt = sr_pkg::SR_ST_IDLE;
            end
         end
         sr_pkg::SR_ST_SREF: begin
            // only cke is looked at
            if (i_cmd.cke) begin
               state_nxt = sr_pkg::SR_ST_XSR;
            end
         end
         sr_pkg::SR_ST_XSR: begin
            if (!i_cmd.cke) begin
               state_nxt = sr_pkg::SR_ST_SREF;
            end else if (xsr_cnt_r == 8'h00) begin
               state_nxt = sr_pkg::SR_ST_IDLE;
            end
         end
         default: state_nxt = sr_pkg::SR_ST_IDLE;
      endcase
   end

   // ==========================================================
   // bank open tracking, one slot per bank
   for (genvar b = 0; b < 8; b++) begin : g_bank
      always_comb begin
         open_nxt[b] = open_r[b];
         if (b >= NBANK) begin
            open_nxt[b] = 1'b0;
         end else if (state_r == sr_pkg::SR_ST_XSR) begin
            open_nxt[b] = 1'b0;
         end else if (act_hit && bank_sel == 3'(b)) begin
            open_nxt[b] = 1'b1;
         end else if (pre_hit && (pre_all || bank_sel == 3'(b))) begin
            open_nxt[b] = 1'b0;
         end
      end
   end

   // ==========================================================
   // state and cke history
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r <= sr_pkg::SR_ST_IDLE;
         cke_prev_r <= 1'b0;
         open_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         cke_prev_r <= i_cmd.cke;
         open_r <= open_nxt;
      end
   end

   // ==========================================================
   // mode registers, written only in normal decoding
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         bank_mask_r <= `SR_BANK_MASK_RST;
         seg_mask_r <= `SR_SEG_MASK_RST;
      end else begin
         if (wr_bank) begin
            bank_mask_r <= mr_op;
         end
         if (wr_seg) begin
            seg_mask_r <= mr_op;
         end
      end
   end

   // ==========================================================
   // exit interval counter, loaded on the cke-high edge
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         xsr_cnt_r <= 8'h00;
      end else if (in_sref) begin
         xsr_cnt_r <= XSR_LAST;
      end else if (xsr_cnt_r != 8'h00) begin
         xsr_cnt_r <= xsr_cnt_r - 8'h01;
      end
   end

   // ==========================================================
   // internal refresh timer, zero on entry for an instant refresh
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         refi_cnt_r <= 8'h00;
         row_r <= '0;
      end else if (!in_sref) begin
         refi_cnt_r <= 8'h00;
      end else if (tick) begin
         refi_cnt_r <= REFI_LAST;
         row_r <= row_r + 1'b1;
      end else begin
         refi_cnt_r <= refi_cnt_r - 8'h01;
      end
   end

   // ==========================================================
   // registered refresh outputs
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ref_r <= '0;
         refab_r <= 1'b0;
      end else begin
         ref_r.fire <= tick && (ref_banks != 8'h00);
         ref_r.banks <= tick ? ref_banks : 8'h00;
         ref_r.seg <= seg_now;
         ref_r.row <= 6'(row_r);
         refab_r <= refab_ok;
      end
   end

   // ==========================================================
   // outputs
   assign o_status.in_sref = in_sref;
   assign o_status.in_pd = (state_r == sr_pkg::SR_ST_PD);
   assign o_status.exiting = (state_r == sr_pkg::SR_ST_XSR);
   assign o_status.cmd_ready = in_idle;
   assign o_status.int_clk_en = !in_sref;
   assign o_ref = ref_r;
   assign o_refab = refab_r;
   assign o_banks_open = open_r;
   assign o_bank_mask = bank_mask_r;
   assign o_seg_mask = seg_mask_r;

   // ==========================================================
   // assertions
   localparam int XSR_N = `SR_XSR_CYC;
   property p_entry;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      sre_hit |=> in_sref;
   endproperty
   a_entry: assert property (p_entry)
      else $error("entry not taken");
   property p_stay;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      in_sref && !i_cmd.cke |=> in_sref;
   endproperty
   a_stay: assert property (p_stay)
      else $error("left self refresh with cke low");
   property p_ignore;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      in_sref |=> $stable(bank_mask_r) && $stable(seg_mask_r);
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("mask changed in self refresh");
   property p_first_ref;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      sre_hit ##1 (in_sref && !i_cmd.cke) |-> tick && !o_status.int_clk_en;
   endproperty
   a_first_ref: assert property (p_first_ref)
      else $error("no refresh at entry");
   property p_xsr_len;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      in_sref && i_cmd.cke ##1 i_cmd.cke [*4] |-> !in_idle ##1 in_idle;
   endproperty
   a_xsr_len: assert property (p_xsr_len)
      else $error("exit interval length wrong");
   property p_xsr_start;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      in_sref && i_cmd.cke |=> o_status.exiting && xsr_cnt_r == XSR_N - 1;
   endproperty
   a_xsr_start: assert property (p_xsr_start)
      else $error("exit timing not started");
   property p_pd_noref;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      o_status.in_pd |=> !o_ref.fire;
   endproperty
   a_pd_noref: assert property (p_pd_noref)
      else $error("refresh in power-down");
   property p_mask;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      tick |=> (o_ref.banks & $past(bank_mask_r)) == 8'h00
         && (!$past(seg_mask_r[seg_now]) || o_ref.banks == 8'h00);
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked bank or segment refreshed");
   property p_mrw;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      wr_bank |=> bank_mask_r == $past(mr_op);
   endproperty
   a_mrw: assert property (p_mrw)
      else $error("bank mask not written");
   property p_refab;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      o_refab |-> $past(open_r) == 8'h00;
   endproperty
   a_refab: assert property (p_refab)
      else $error("refresh taken with open bank");
   property p_exit_idle;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      o_status.exiting ##1 in_idle |-> open_r == 8'h00;
   endproperty
   a_exit_idle: assert property (p_exit_idle)
      else $error("bank open after exit");
   c_entry: cover property (@(posedge i_clk_sys) sre_hit);
   c_exit: cover property (@(posedge i_clk_sys)
      o_status.exiting ##1 in_idle);
   c_reentry: cover property (@(posedge i_clk_sys)
      o_status.exiting ##1 in_sref);
   c_pd: cover property (@(posedge i_clk_sys) pd_hit);
endmodule : sr_self_refresh

//--- sr_ctl_model.sv
`timescale 1ns/100ps
`include "sr_map.svh"
// ==========================================
// controller model driving the command bus
module sr_ctl_model (
   // clock
   input wire logic i_clk_sys,
   // command bus to the device
   output sr_pkg::sr_cmd_t o_cmd
);
   // one command, launched off the falling edge
   task automatic cmd(input logic ck, input logic cs,
         input logic [9:0] car, input logic [9:0] caf);
      @(negedge i_clk_sys);
      o_cmd <= '{ck, cs, car, caf};
   endtask : cmd
   // nop cycles, ca lines flip as they are not looked at
   task automatic nop(input int n, input logic ck);
      repeat (n) cmd(ck, 1'b1, ~o_cmd.ca_r, ~o_cmd.ca_f);
   endtask : nop
   // mode register write
   task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
      cmd(1'b1, 1'b0, {ma[5:0], 4'h0}, {op, ma[7:6]});
   endtask : mrw
   // entry from all banks idle, cke high the cycle before
   task automatic sref_in();
      nop(1, 1'b1);
      cmd(1'b0, 1'b0, 10'h004, 10'h000);
      nop(1, 1'b0);
   endtask : sref_in
   // resident: cke low, clock kept running, junk elsewhere
   task automatic sref_hold(input int n);
      repeat (n) cmd(1'b0, ~o_cmd.cs_b, ~o_cmd.ca_r,
         o_cmd.ca_f + 10'h001);
   endtask : sref_hold
   // exit: stable clock, cke high and nops through the interval
   task automatic sref_out();
      nop(`SR_XSR_CYC + 1, 1'b1);
   endtask : sref_out
   // bus idle with cke low before reset release
   initial o_cmd = '{1'b0, 1'b1, 10'h000, 10'h000};
endmodule : sr_ctl_model

//--- sr_self_refresh_tb.sv
`timescale 1ns/100ps
`include "sr_map.svh"
// ==========================================
// self checking bench for the self refresh block
module sr_self_refresh_tb;
   localparam logic [7:0] BM = 8'h82; // banks 1 and 7 masked
   localparam logic [7:0] SM = 8'h84; // segments 2 and 7 masked
   logic i_clk_sys = 1'b0; // device clock
   logic i_rst_b = 1'b0; // reset, active low
   sr_pkg::sr_cmd_t cmd; // command bus
   sr_pkg::sr_status_t st; // status
   sr_pkg::sr_ref_t rf; // refresh ticks
   logic refab; // all-bank refresh taken
   logic [7:0] bo, bm, sm; // open banks, masks
   int miscompares = 0;
   int checked = 0;
   // 25 MHz clock
   always #20 i_clk_sys = ~i_clk_sys;
   sr_ctl_model sr_ctl_model_i (.i_clk_sys(i_clk_sys), .o_cmd(cmd));
   sr_self_refresh sr_self_refresh_i (.i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b), .i_cmd(cmd), .o_status(st), .o_ref(rf),
      .o_refab(refab), .o_banks_open(bo), .o_bank_mask(bm),
      .o_seg_mask(sm));
   // ==========================================
   // compare and report
   task automatic chk(input string what, input logic [7:0] seen,
         input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // verdict and end of run
   task automatic results();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results
   // ==========================================
   // masks written at 10h and 11h, other address ignored
   task automatic t_mrw();
      chk("bank mask rst", bm, 8'h00);
      chk("cmd_ready rst", st.cmd_ready, 1'b1);
      sr_ctl_model_i.mrw(8'h10, BM);
      sr_ctl_model_i.mrw(8'h11, SM);
      sr_ctl_model_i.mrw(8'h12, 8'hff);
      sr_ctl_model_i.nop(2, 1'b1);
      chk("bank mask", bm, BM);
      chk("seg mask", sm, SM);
      $display("t_mrw done");
   endtask : t_mrw
   // residence: ticks follow bank and segment masks
   task automatic t_sref();
      int fires, first, last, seg;
      fires = 0;
      first = -1;
      last = 0;
      sr_ctl_model_i.sref_in();
      chk("in_sref", st.in_sref, 1'b1);
      chk("int clock", st.int_clk_en, 1'b0);
      for (int i = 0; i < 64 * `SR_REFI_CYC + 4; i++) begin
         sr_ctl_model_i.sref_hold(1);
         // one tick slot per interval, eight rows to a segment
         if (i % `SR_REFI_CYC == 0) begin
            seg = (i / `SR_REFI_CYC / 8) % 8;
            chk("slot banks", rf.banks, SM[seg] ? 8'h00 : ~BM);
         end else begin
            chk("idle banks", rf.banks, 8'h00);
         end
         if (rf.fire === 1'b1) begin
            if (first < 0) first = i;
            if (fires > 0) chk("tick gap", (i - last) % `SR_REFI_CYC, 0);
            last = i;
            fires++;
            // a fired tick never lands in a masked segment
            chk("seg off", SM[rf.seg], 1'b0);
            chk("tick banks", rf.banks, ~BM);
            chk("tick row", rf.row, (i / `SR_REFI_CYC) % 64);
         end
      end
      chk("first tick", first inside {[0:`SR_CKESR_CYC]}, 1'b1);
      chk("ticks seen", fires > 40, 1'b1);
      chk("still in", st.in_sref, 1'b1);
      $display("t_sref done");
   endtask : t_sref
   // exit interval counted from the cke high edge
   task automatic t_exit();
      sr_ctl_model_i.nop(1, 1'b1);
      for (int j = 1; j <= `SR_XSR_CYC; j++) begin
         sr_ctl_model_i.nop(1, 1'b1);
         chk("exiting", st.exiting, 1'b1);
      end
      sr_ctl_model_i.nop(1, 1'b1);
      chk("ready", st.cmd_ready, 1'b1);
      chk("banks idle", bo, 8'h00);
      chk("int clock", st.int_clk_en, 1'b1);
      $display("t_exit done");
   endtask : t_exit
   // all-bank refresh only with every bank idle
   task automatic t_ref();
      int n;
      sr_ctl_model_i.cmd(1'b1, 1'b0, {3'd3, 7'h02}, 10'h000);
      sr_ctl_model_i.nop(1, 1'b1);
      chk("open bank", bo, 8'h08);
      sr_ctl_model_i.cmd(1'b1, 1'b0, 10'h004, 10'h000);
      sr_ctl_model_i.nop(1, 1'b1);
      n = refab;
      sr_ctl_model_i.nop(1, 1'b1);
      chk("ref refused", n + refab, 0);
      sr_ctl_model_i.cmd(1'b1, 1'b0, 10'h01b, 10'h000);
      sr_ctl_model_i.nop(1, 1'b1);
      chk("pre all", bo, 8'h00);
      sr_ctl_model_i.cmd(1'b1, 1'b0, 10'h004, 10'h000);
      sr_ctl_model_i.nop(1, 1'b1);
      n = refab;
      sr_ctl_model_i.nop(1, 1'b1);
      chk("ref taken", n + refab, 1);
      chk("idle after", bo, 8'h00);
      $display("t_ref done");
   endtask : t_ref
   // power-down performs no refresh
   task automatic t_pd();
      int fires;
      fires = 0;
      sr_ctl_model_i.nop(2, 1'b0);
      chk("in_pd", st.in_pd, 1'b1);
      for (int i = 0; i < 3 * `SR_REFI_CYC; i++) begin
         sr_ctl_model_i.nop(1, 1'b0);
         if (rf.fire !== 1'b0) fires++;
      end
      chk("pd ticks", fires, 0);
      sr_ctl_model_i.nop(3, 1'b1);
      chk("pd out", st.cmd_ready, 1'b1);
      $display("t_pd done");
   endtask : t_pd
   // cke dropped inside the exit interval returns to self refresh
   task automatic t_reenter();
      sr_ctl_model_i.sref_in();
      sr_ctl_model_i.sref_hold(`SR_CKESR_CYC + 2);
      sr_ctl_model_i.nop(2, 1'b1);
      chk("exit started", st.exiting, 1'b1);
      sr_ctl_model_i.nop(2, 1'b0);
      chk("re-entered", st.in_sref, 1'b1);
      sr_ctl_model_i.sref_hold(`SR_CKESR_CYC + 2);
      sr_ctl_model_i.sref_out();
      sr_ctl_model_i.nop(1, 1'b1);
      chk("ready again", st.cmd_ready, 1'b1);
      chk("banks idle again", bo, 8'h00);
      $display("t_reenter done");
   endtask : t_reenter
   // ==========================================
   // main sequence
   initial begin
      repeat (2) @(negedge i_clk_sys);
      i_rst_b = 1'b1;
      sr_ctl_model_i.nop(2, 1'b1);
      t_mrw();
      t_sref();
      t_exit();
      t_ref();
      t_pd();
      t_reenter();
      results();
   end
   // watchdog, well past the expected run
   initial begin
      #(15000 * 40);
      miscompares++;
      results();
   end
endmodule : sr_self_refresh_tb
